// ===== include/ldp_pkg.sv
// Constants and types shared by the two-wire target port of the LED driver
`default_nettype none
package ldp_pkg;

  // Target address layout
  localparam logic [4:0] ADDR_FIXED = 5'h1D;
  localparam int ADDR_HI_MSB = 7;
  localparam int ADDR_HI_LSB = 3;
  localparam int ADDR_LO_MSB = 2;
  localparam int ADDR_LO_LSB = 1;
  localparam int DIR_POS = 0;

  // Low address bits by strap wiring
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h3;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;

  // Register pointer and read data
  localparam logic [7:0] PTR_STATE = 8'h08;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] READ_FILL = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Byte framing
  localparam int TX_MSB = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h7;

  // Fastest link rate; oversampling margin in system cycles
  localparam int CLK_MHZ = 100;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;

  // Positions inside the synchroniser vectors
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_TGL = 2;
  localparam int SY_STRAP = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_PTR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_RACK = 3'h5,
    ST_IGNORE = 3'h6
  } ldp_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] ptr;
    logic [7:0] data;
  } ldp_wr_t;

  typedef struct packed {
    logic bit_val;
    logic tgl;
  } ldp_smp_t;

  typedef struct packed {
    ldp_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic ack_pend;
    logic oe;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] p2;
    logic stab;
    logic seen_lo;
    logic seen_hi;
    logic neq_scl;
    logic neq_sda;
    ldp_wr_t wr;
  } ldp_core_t;

  localparam ldp_core_t CORE_RESET = '0;
  localparam ldp_smp_t SMP_RESET = '0;

endpackage : ldp_pkg
`default_nettype wire

// ===== logic/ldp_bit_sampler.sv
// Link-clock bit sampler: latches the data line on each serial clock rise
`default_nettype none
module ldp_bit_sampler
  import ldp_pkg::*;
(
  input wire logic scl_clk_i,
  input wire logic reset_n_i,
  input wire logic sda_i,
  output var ldp_smp_t smp_o
);

  ldp_smp_t r;
  ldp_smp_t next_r;

  // Bit taken at clock-high, toggle marks each new bit
  always_comb begin
    next_r = r;
    next_r.bit_val = sda_i;
    next_r.tgl = ~r.tgl;
  end

  always_ff @(posedge scl_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= SMP_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign smp_o = r;

endmodule : ldp_bit_sampler
`default_nettype wire

// ===== logic/ldp_target_port.sv
// Two-wire target port: address match, pointer, writes and reads
`default_nettype none

// Operation
// - First byte after start: seven address bits, then direction, 0 write, 1 read.
// - Answer only when top five bits are 11101 and low two match strap.
// - Strap wiring gives low bits: ground 00, supply 11, clock 01, data 10.
// - Data sampled while clock high; driven bits held stable through clock high.
// - Start is data falling with clock high; begins address comparison.
// - Matching address acknowledged by pulling data low through ninth clock.
// - Pointer byte follows the address, MSB first, and is acknowledged.
// - Write data bytes arrive MSB first and each one is acknowledged.
// - Stop is data rising with clock high; device returns to idle.
// - Pointer increments by one during each written data byte acknowledge.
// - Read: write address and pointer, repeated start, read address, data returned.
// - Serial clock up to 400 kHz; device works at any slower rate.
// - Clock line is input only; data line only pulled low, never driven high.
// - Pointer 08h reads the input states; other registers are write-only.
module ldp_target_port
  import ldp_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic strap_i,
  input wire logic [7:0] gpio_state_i,
  output ldp_wr_t wr_o,
  output logic busy_o
);

  ldp_core_t r;
  ldp_core_t next_r;
  ldp_smp_t smp;

  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_evt;
  logic steady;
  logic [7:0] rx_byte;
  logic [7:0] read_val;

  // Decode low address bits from how the strap follows the bus lines
  function automatic logic [1:0] strap_code(input ldp_core_t c);
    logic [1:0] code;
    code = STRAP_GND;
    if (c.seen_lo && c.seen_hi && !c.neq_scl) begin
      code = STRAP_SCL;
    end else if (c.seen_lo && c.seen_hi && !c.neq_sda) begin
      code = STRAP_SDA;
    end else if (c.seen_hi) begin
      code = STRAP_VCC;
    end
    return code;
  endfunction : strap_code

  // Address byte compared against fixed part and strap part
  function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] code);
    return (b[ADDR_HI_MSB:ADDR_HI_LSB] == ADDR_FIXED) &&
           (b[ADDR_LO_MSB:ADDR_LO_LSB] == code);
  endfunction : addr_hit

  // Serial-clock domain bit capture
  ldp_bit_sampler ldp_bit_sampler_inst (
    .scl_clk_i(scl_i),
    .reset_n_i(reset_n_i),
    .sda_i(sda_i),
    .smp_o(smp)
  );

  // Synchronised views; oversampling keeps 400 kHz and slower exact
  assign scl_s = r.s2[SY_SCL];
  assign sda_s = r.s2[SY_SDA];
  assign strap_s = r.s2[SY_STRAP];
  assign start_det = scl_s && r.p2[SY_SCL] && r.p2[SY_SDA] && !sda_s;
  assign stop_det = scl_s && r.p2[SY_SCL] && !r.p2[SY_SDA] && sda_s;
  assign scl_fall = r.p2[SY_SCL] && !scl_s;
  assign bit_evt = r.s2[SY_TGL] ^ r.p2[SY_TGL];
  assign steady = (r.s2[SY_SCL] == r.p2[SY_SCL]) && (r.s2[SY_SDA] == r.p2[SY_SDA]) &&
                  (r.s2[SY_STRAP] == r.p2[SY_STRAP]);
  assign rx_byte = {r.shreg[TX_MSB-1:0], smp.bit_val};
  assign read_val = (r.ptr == PTR_STATE) ? gpio_state_i : READ_FILL;

  always_comb begin
    next_r = r;
    next_r.wr.valid = 1'h0;
    next_r.s1 = {strap_i, smp.tgl, sda_i, scl_i};
    next_r.s2 = r.s1;
    next_r.p2 = r.s2;
    next_r.stab = steady;

    // Strap tracking only over settled lines
    if (steady && r.stab) begin
      if (strap_s) begin
        next_r.seen_hi = 1'h1;
      end else begin
        next_r.seen_lo = 1'h1;
      end
      if (strap_s != scl_s) begin
        next_r.neq_scl = 1'h1;
      end
      if (strap_s != sda_s) begin
        next_r.neq_sda = 1'h1;
      end
    end

    if (start_det) begin
      // Start or repeated start from any state, pointer kept
      next_r.state = ST_ADDR;
      next_r.cnt = '0;
      next_r.ack_pend = 1'h0;
      next_r.oe = 1'h0;
      next_r.seen_lo = 1'h0;
      next_r.seen_hi = 1'h0;
      next_r.neq_scl = 1'h0;
      next_r.neq_sda = 1'h0;
    end else if (stop_det) begin
      next_r.state = ST_IDLE;
      next_r.cnt = '0;
      next_r.ack_pend = 1'h0;
      next_r.oe = 1'h0;
    end else begin
      // Drive changes only while the clock is low
      if (scl_fall) begin
        next_r.oe = (r.cnt == BYTE_BITS && r.ack_pend) ||
                    (r.state == ST_RDATA && !r.tx[TX_MSB]);
      end

      if (bit_evt) begin
        unique case (r.state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (r.cnt != BYTE_BITS) begin
              next_r.shreg = rx_byte;
              next_r.cnt = r.cnt + CNT_STEP;
              if (r.cnt == CNT_LAST) begin
                next_r.ack_pend = (r.state != ST_ADDR) ||
                                  addr_hit(rx_byte, strap_code(r));
              end
            end else begin
              // Ninth clock: acknowledge slot ends here
              next_r.cnt = '0;
              next_r.ack_pend = 1'h0;
              if (!r.ack_pend) begin
                next_r.state = ST_IGNORE;
              end else if (r.state == ST_ADDR) begin
                if (r.shreg[DIR_POS]) begin
                  next_r.state = ST_RDATA;
                  next_r.tx = read_val;
                end else begin
                  next_r.state = ST_PTR;
                end
              end else if (r.state == ST_PTR) begin
                next_r.ptr = r.shreg;
                next_r.state = ST_WDATA;
              end else begin
                next_r.wr.valid = 1'h1;
                next_r.wr.ptr = r.ptr;
                next_r.wr.data = r.shreg;
                next_r.ptr = r.ptr + PTR_STEP;
              end
            end
          end
          ST_RDATA: begin
            next_r.tx = {r.tx[TX_MSB-1:0], 1'h0};
            next_r.cnt = r.cnt + CNT_STEP;
            if (r.cnt == CNT_LAST) begin
              next_r.state = ST_RACK;
              next_r.cnt = '0;
            end
          end
          ST_RACK: begin
            if (!smp.bit_val) begin
              next_r.state = ST_RDATA;
              next_r.tx = read_val;
            end else begin
              next_r.state = ST_IGNORE;
            end
          end
          ST_IDLE, ST_IGNORE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o = 1'h0;
  assign sda_oe_o = r.oe;
  assign wr_o = r.wr;
  assign busy_o = (r.state != ST_IDLE) && (r.state != ST_IGNORE);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_start_addr;
    start_det |=> (r.state == ST_ADDR) && (r.cnt == '0) && !r.oe;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not followed by address phase");

  property p_stop_idle;
    stop_det |=> (r.state == ST_IDLE) && !r.oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

  property p_ptr_keep;
    start_det |=> r.ptr == $past(r.ptr);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer lost on repeated start");

  property p_wr_step;
    r.wr.valid |-> r.ptr == (r.wr.ptr + PTR_STEP);
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("pointer not advanced after write");

  property p_oe_edges;
    $changed(r.oe) |-> $past(scl_fall || start_det || stop_det);
  endproperty
  a_oe_edges: assert property (p_oe_edges) else $error("data drive changed with clock high");

  property p_addr_ack;
    (r.state == ST_ADDR && r.oe) |->
      (r.shreg[ADDR_HI_MSB:ADDR_HI_LSB] == ADDR_FIXED) &&
      (r.shreg[ADDR_LO_MSB:ADDR_LO_LSB] == strap_code(r));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acknowledged a foreign address");

  property p_ignore_quiet;
    (r.state == ST_IGNORE) |-> !r.oe && !r.wr.valid;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored transfer drove bus");

  property p_read_src;
    (r.state == ST_RDATA && r.ptr != PTR_STATE && scl_fall) |=> r.oe;
  endproperty
  a_read_src: assert property (p_read_src) else $error("write-only register read nonzero");

  property p_ack_len;
    ($rose(r.oe) && r.state == ST_PTR) |=> r.oe [*8];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("pointer acknowledge released early");

  property p_wack_len;
    ($rose(r.oe) && r.state == ST_WDATA) |=> r.oe [*8];
  endproperty
  a_wack_len: assert property (p_wack_len) else $error("data acknowledge released early");

  property p_oe_cause;
    $rose(r.oe) |->
      ($past(r.state) == ST_RDATA) || ($past(r.cnt) == BYTE_BITS && $past(r.ack_pend));
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data pulled low outside ack or read");

  property p_idle_quiet;
    (r.state == ST_IDLE) |-> !r.oe && !r.wr.valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle port drove bus or wrote");

  property p_wr_pulse;
    r.wr.valid |=> !r.wr.valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  property p_ignore_hold;
    (r.state == ST_IGNORE && !start_det && !stop_det) |=> r.state == ST_IGNORE;
  endproperty
  a_ignore_hold: assert property (p_ignore_hold) else $error("ignored transfer resumed");

  property p_rd_load;
    (r.state == ST_RDATA && r.cnt == '0 && scl_fall) |=> r.oe == !read_val[TX_MSB];
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("first read bit not from register");

  property p_rd_nowrite;
    (r.state == ST_RDATA || r.state == ST_RACK) |-> !r.wr.valid;
  endproperty
  a_rd_nowrite: assert property (p_rd_nowrite) else $error("write strobe during read");

  property p_ptr_moves;
    $changed(r.ptr) |-> r.wr.valid || (r.state == ST_WDATA && $past(r.state) == ST_PTR);
  endproperty
  a_ptr_moves: assert property (p_ptr_moves) else $error("pointer moved without write");

endmodule : ldp_target_port
`default_nettype wire

// ===== verif/ldp_host_model.sv
// Behavioural two-wire bus master facing the target port
`default_nettype none
module ldp_host_model
  import ldp_pkg::*;
#(
  parameter int T_LO = 1500,
  parameter int T_HI = 1000
)(
  input wire logic sda_i,
  input wire logic [7:0] stretch_i,
  output var logic scl_o,
  output var logic sda_rel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  task automatic bit_cyc(input logic b, output logic s);
    #(T_LO / 2 + 100 * stretch_i);
    sda_rel_o = b;
    #(T_LO / 2);
    scl_o = 1'b1;
    #(T_HI / 2);
    s = sda_i;
    #(T_HI / 2);
    scl_o = 1'b0;
  endtask : bit_cyc
  task automatic start_c();
    #(13 - $time % 10);
    if (scl_o == 1'b0) begin
      #(T_LO / 2);
      sda_rel_o = 1'b1;
      #(T_LO / 2);
      scl_o = 1'b1;
      #(T_HI);
    end
    sda_rel_o = 1'b0;
    #(T_HI);
    scl_o = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #(T_LO / 2);
    sda_rel_o = 1'b0;
    #(T_LO / 2);
    scl_o = 1'b1;
    #(T_HI);
    sda_rel_o = 1'b1;
    #(T_LO);
  endtask : stop_c
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, ack);
  endtask : send_byte
  task automatic recv_byte(input logic ack_bit, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, s);
      b[i] = s;
    end
    bit_cyc(ack_bit, s);
  endtask : recv_byte
endmodule : ldp_host_model
`default_nettype wire

// ===== verif/ldp_target_port_bench.sv
// Self-checking bench for the two-wire target port
`default_nettype none
module ldp_target_port_bench
  import ldp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, reset_n_i, scl, sda_rel, sda, strap, busy_o, sda_oe, sda_drv;
  logic [1:0] strap_sel;
  logic [7:0] gpio_state, stretch;
  ldp_wr_t wr_o;
  ldp_wr_t exp_wr[$];
  int n_errors, check_count;
  integer seed;
  assign sda = sda_oe ? (sda_rel & sda_drv) : sda_rel;
  assign strap = (strap_sel == 2'h0) ? 1'b0 : (strap_sel == 2'h1) ? 1'b1 :
                 (strap_sel == 2'h2) ? scl : sda;
  ldp_target_port ldp_target_port_inst (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .strap_i(strap), .gpio_state_i(gpio_state),
    .wr_o(wr_o), .busy_o(busy_o)
  );
  ldp_host_model host_inst (
    .sda_i(sda), .stretch_i(stretch), .scl_o(scl), .sda_rel_o(sda_rel)
  );
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic cmp_wr(input ldp_wr_t got, input ldp_wr_t exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_wr
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  function automatic logic [1:0] code_of(input logic [1:0] sel);
    case (sel)
      2'h0: return STRAP_GND;
      2'h1: return STRAP_VCC;
      2'h2: return STRAP_SCL;
      default: return STRAP_SDA;
    endcase
  endfunction : code_of
  task automatic begin_txn(input logic [1:0] sel);
    @(posedge clock_i);
    strap_sel <= sel;
    stretch <= 8'($random(seed) & 3);
    repeat (4) @(posedge clock_i);
    host_inst.start_c();
  endtask : begin_txn
  task automatic send_chk(input logic [7:0] b, input logic exp_ack);
    logic ack;
    host_inst.send_byte(b, ack);
    cmp_byte({7'h0, ack}, {7'h0, exp_ack});
  endtask : send_chk
  task automatic end_txn();
    host_inst.stop_c();
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    cmp_byte({7'h0, busy_o}, 8'h00);
  endtask : end_txn
  task automatic wr_txn(input logic [1:0] sel, input logic [7:0] ptr, input int n);
    logic [7:0] d;
    begin_txn(sel);
    send_chk({ADDR_FIXED, code_of(sel), 1'b0}, 1'b0);
    send_chk(ptr, 1'b0);
    cmp_byte({7'h0, busy_o}, 8'h01);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      exp_wr.push_back({1'b1, ptr + 8'(i), d});
      send_chk(d, 1'b0);
    end
    end_txn();
  endtask : wr_txn
  task automatic rd_txn(input logic [7:0] ptr, input int n);
    logic [7:0] b;
    begin_txn(2'h2);
    send_chk({ADDR_FIXED, STRAP_SCL, 1'b0}, 1'b0);
    send_chk(ptr, 1'b0);
    host_inst.start_c();
    send_chk({ADDR_FIXED, STRAP_SCL, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_inst.recv_byte(i == n - 1, b);
      cmp_byte(b, (ptr == PTR_STATE) ? gpio_state : READ_FILL);
    end
    end_txn();
  endtask : rd_txn
  always @(negedge clock_i) begin
    if (wr_o.valid === 1'b1) begin
      if (exp_wr.size() == 0) cmp_wr(wr_o, '0);
      else cmp_wr(wr_o, exp_wr.pop_front());
    end
  end
  initial begin
    repeat (95000) @(posedge clock_i);
    n_errors++;
    test_done();
  end
  initial begin
    seed = 85380;
    n_errors = 0;
    check_count = 0;
    reset_n_i = 1'b0;
    strap_sel = 2'h0;
    gpio_state = 8'h00;
    stretch = 8'h00;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    for (int s = 0; s < 4; s++) wr_txn(2'(s), (s == 3) ? 8'hFF : 8'($random(seed)), 2);
    begin_txn(2'h0);
    send_chk({ADDR_FIXED ^ 5'h10, STRAP_GND, 1'b0}, 1'b1);
    end_txn();
    begin_txn(2'h0);
    send_chk({ADDR_FIXED, STRAP_VCC, 1'b0}, 1'b1);
    end_txn();
    @(posedge clock_i);
    gpio_state <= 8'($random(seed));
    rd_txn(PTR_STATE, 2);
    rd_txn(8'h05, 1);
    repeat (20) @(posedge clock_i);
    cmp_byte(8'(exp_wr.size()), 8'h00);
    test_done();
  end
endmodule : ldp_target_port_bench
`default_nettype wire
